// >>> wft_pkg.sv
// Constants for the watchdog and fetch-trap block
package wft_pkg;
    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h34;
    localparam logic [7:0] CODE_ADDR = 8'h38;
    localparam logic [7:0] STAT_ADDR = 8'h3c;
    // Control register fields
    localparam int RAM_TRAP_BIT = 5;
    localparam int TRAP_ACT_BIT = 4;
    localparam int WD_ON_BIT = 3;
    localparam int PERIOD_HI = 2;
    localparam int PERIOD_LO = 1;
    localparam int OVF_ACT_BIT = 0;
    // Reset values of the control fields
    localparam logic RAM_TRAP_RST = 1'b1;
    localparam logic TRAP_ACT_RST = 1'b1;
    localparam logic WD_ON_RST = 1'b1;
    localparam logic [1:0] PERIOD_RST = 2'h0;
    localparam logic OVF_ACT_RST = 1'b1;
    // Codes accepted by the code register
    localparam logic [7:0] CLEAR_CODE = 8'h4e;
    localparam logic [7:0] DISABLE_CODE = 8'hb1;
    localparam logic [7:0] ARM_CODE = 8'hd2;
    // Overflow exponents: fast base, slow base, step per code
    localparam logic [4:0] FAST_EXP = 5'h19;
    localparam logic [4:0] SLOW_EXP = 5'h11;
    localparam logic [4:0] EXP_STEP = 5'h02;
    // Two-stage binary counter after the divider
    localparam int BIN_W = 2;
    localparam int DIV_W = 23;
    // Internal reset time: 24 fast-clock periods, fast clock equals clk
    localparam int CLK_NS = 10;
    localparam int FC_NS = 10;
    localparam int RESET_FC_PERIODS = 24;
    localparam int RESET_CYCLES = (RESET_FC_PERIODS * FC_NS) / CLK_NS;
    // Fetch address areas
    localparam logic [15:0] SREG_LO = 16'h0000;
    localparam logic [15:0] SREG_HI = 16'h003f;
    localparam logic [15:0] RAM_LO = 16'h0040;
    localparam logic [15:0] RAM_HI = 16'h083f;
    localparam logic [15:0] BANK_LO = 16'h0f80;
    localparam logic [15:0] BANK_HI = 16'h0fff;
    // Bus responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : wft_pkg

// >>> wft_watchdog_trap.sv
// Watchdog timer and instruction-fetch trap with an AXI4-Lite slave
// Summary of operation
// R1: Enable bit resets to one; counts automatically
// R2: Period select picks overflow exponent per clock
// R3: Overflow action zero interrupt, one reset; sticky zero
// R4: Control register write-only; reads return zero
// R5: Disable code accepted only while enable bit zero
// R6: Clear code clears binary counter; software refreshes
// R7: Software disables via master flag, clear, enable, code
// R8: Binary counter held cleared while disabled
// R9: Overflow with action zero raises watchdog interrupt
// R10: Watchdog interrupt ignores the master flag
// R11: Watchdog interrupt raised even during any service
// R12: Overflow with action one resets, restarts oscillator
// R13: Stack pointer loaded before interrupt actions
// R14: No counter clear inside interrupt service
// R15: Disable or clear around stop mode
// R16: RAM trap setting takes effect after arm code
// R17: Special and bank areas always trap; RAM if enabled
// R18: Trap action zero interrupt, one reset
// R19: Trap interrupt non-maskable, raised during any service
// R20: Trap reset lasts at most 24 fast periods
// R21: Clear code leaves internal divider running
// R22: Counting pauses in stop, idle and sleep
// R23: Other code values have no effect
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module wft_watchdog_trap (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic slowMode,
    input wire logic slow_prescale_sel,
    input wire logic slowTick,
    input wire logic pauseMode,
    input wire logic fetchValid,
    input wire logic [15:0] fetchAddr,
    output logic watchdog_irq,
    output logic fetch_trap_irq,
    output logic internalReset,
    output logic fastOscRestart
);

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic inArea(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        inArea = (a >= lo) && (a <= hi);
    endfunction : inArea

    function automatic logic [4:0] periodExp(input logic [1:0] sel, input logic slow);
        logic [4:0] base;
        base = slow ? wft_pkg::SLOW_EXP : wft_pkg::FAST_EXP;
        periodExp = base - 5'(sel * wft_pkg::EXP_STEP);
    endfunction : periodExp

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic doWrite;
    logic wrLane0;
    logic ctrlWr;
    logic codeWr;
    logic [7:0] wByte;

    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrLane0 = doWrite && wStrb_reg[0];
    assign wByte = wData_reg[7:0];
    assign ctrlWr = wrLane0 && (awAddr_reg == wft_pkg::CTRL_ADDR);
    assign codeWr = wrLane0 && (awAddr_reg == wft_pkg::CODE_ADDR);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld_reg <= 1'b0;
            wData_reg <= 32'h0;
            wStrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= wft_pkg::RESP_OK;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_reg == wft_pkg::CTRL_ADDR ||
                            awAddr_reg == wft_pkg::CODE_ADDR) ?
                           wft_pkg::RESP_OK : wft_pkg::RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control state
    logic enBit_reg;
    logic running_reg;
    logic [1:0] period_reg;
    logic ovfAct_reg;
    logic trapAct_reg;
    logic ramTrapNew_reg;
    logic ramTrapOn_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // R1: enabled out of reset
            enBit_reg <= wft_pkg::WD_ON_RST;
            period_reg <= wft_pkg::PERIOD_RST;
            trapAct_reg <= wft_pkg::TRAP_ACT_RST;
            ramTrapNew_reg <= wft_pkg::RAM_TRAP_RST;
            ovfAct_reg <= wft_pkg::OVF_ACT_RST;
        end else if (ctrlWr) begin
            enBit_reg <= wByte[wft_pkg::WD_ON_BIT];
            period_reg <= wByte[wft_pkg::PERIOD_HI:wft_pkg::PERIOD_LO];
            trapAct_reg <= wByte[wft_pkg::TRAP_ACT_BIT];
            ramTrapNew_reg <= wByte[wft_pkg::RAM_TRAP_BIT];
            // R3: once zero, stays zero
            ovfAct_reg <= ovfAct_reg & wByte[wft_pkg::OVF_ACT_BIT];
        end
    end

    // Running flag drops only on the accepted disable code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            running_reg <= wft_pkg::WD_ON_RST;
        end else if (ctrlWr && wByte[wft_pkg::WD_ON_BIT]) begin
            running_reg <= 1'b1;
        // R5: disable code needs enable bit zero
        end else if (codeWr && wByte == wft_pkg::DISABLE_CODE && !enBit_reg) begin
            running_reg <= 1'b0;
        end
    end

    // R16: RAM trap setting armed by code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramTrapOn_reg <= wft_pkg::RAM_TRAP_RST;
        end else if (codeWr && wByte == wft_pkg::ARM_CODE) begin
            ramTrapOn_reg <= ramTrapNew_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Divider and binary counter
    logic [wft_pkg::DIV_W-1:0] div_reg;
    logic [wft_pkg::BIN_W-1:0] bin_reg;
    logic useSlow;
    logic srcEn;
    logic [4:0] ovfExp;
    logic [wft_pkg::DIV_W-1:0] tapMask;
    logic stageTick;
    logic overflow;
    logic clearHit;

    assign useSlow = slowMode || slow_prescale_sel;
    // R22: no counting while paused
    assign srcEn = (useSlow ? slowTick : 1'b1) && !pauseMode;
    // R2: exponent from period select and source
    assign ovfExp = periodExp(period_reg, useSlow);
    assign tapMask = (wft_pkg::DIV_W)'((24'h1 << (ovfExp - 5'(wft_pkg::BIN_W))) - 24'h1);
    assign stageTick = srcEn && ((div_reg & tapMask) == tapMask);
    assign overflow = running_reg && stageTick && (&bin_reg) && !clearHit;
    // R23: only the exact clear code counts
    assign clearHit = codeWr && wByte == wft_pkg::CLEAR_CODE;

    // R21: divider never cleared by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (srcEn) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bin_reg <= '0;
        // R8: held cleared while disabled
        end else if (!running_reg) begin
            bin_reg <= '0;
        // R6: clear code clears counter
        end else if (clearHit) begin
            bin_reg <= '0;
        end else if (stageTick) begin
            bin_reg <= bin_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fetch trap
    logic trapHit;

    // R17: areas that trap
    assign trapHit = fetchValid && (inArea(fetchAddr, wft_pkg::SREG_LO, wft_pkg::SREG_HI) ||
                     inArea(fetchAddr, wft_pkg::BANK_LO, wft_pkg::BANK_HI) ||
                     (ramTrapOn_reg && inArea(fetchAddr, wft_pkg::RAM_LO, wft_pkg::RAM_HI)));

    ////////////////////////////////////////////////////////////////////
    // Requests out; no master flag or in-service gating on purpose
    logic [4:0] rstCnt_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_irq <= 1'b0;
            fetch_trap_irq <= 1'b0;
        end else begin
            // R9: R10: R11: overflow interrupt, never masked
            watchdog_irq <= overflow && !ovfAct_reg;
            // R18: R19: trap interrupt, never masked
            fetch_trap_irq <= trapHit && !trapAct_reg;
        end
    end

    // R12: R20: internal reset of bounded length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstCnt_reg <= 5'h0;
            internalReset <= 1'b0;
            fastOscRestart <= 1'b0;
        end else begin
            fastOscRestart <= 1'b0;
            if (rstCnt_reg == 5'h0 && ((overflow && ovfAct_reg) ||
                                       (trapHit && trapAct_reg))) begin
                rstCnt_reg <= 5'(wft_pkg::RESET_CYCLES);
                internalReset <= 1'b1;
                fastOscRestart <= slowMode;
            end else if (rstCnt_reg != 5'h0) begin
                rstCnt_reg <= rstCnt_reg - 5'h1;
                internalReset <= rstCnt_reg != 5'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel
    logic [31:0] rdMux;

    // R4: control and code registers read as zero
    always_comb begin
        rdMux = 32'h0;
        if (s_axi_araddr == wft_pkg::STAT_ADDR) begin
            rdMux = {24'h0, 1'b0, ramTrapOn_reg, trapAct_reg, enBit_reg,
                     running_reg, ovfAct_reg, bin_reg};
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= wft_pkg::RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= (s_axi_araddr == wft_pkg::CTRL_ADDR ||
                            s_axi_araddr == wft_pkg::CODE_ADDR ||
                            s_axi_araddr == wft_pkg::STAT_ADDR) ?
                           wft_pkg::RESP_OK : wft_pkg::RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sticky_action_a: assert property (!ovfAct_reg |=> !ovfAct_reg) // R3
        else $error("overflow action returned to one");
    disable_gate_a: assert property ($fell(running_reg) |-> !$past(enBit_reg)) // R5
        else $error("disabled while enable bit set");
    clear_count_a: assert property (clearHit && running_reg |=> bin_reg == '0) // R6
        else $error("clear code left counter");
    held_clear_a: assert property (!running_reg |=> bin_reg == '0) // R8
        else $error("counter moved while disabled");
    wd_irq_a: assert property (overflow && !ovfAct_reg |=> watchdog_irq) // R9
        else $error("overflow interrupt missing");
    wd_reset_a: assert property (overflow && ovfAct_reg && rstCnt_reg == 5'h0
                                 |=> internalReset [*8]) // R12
        else $error("overflow reset too short");
    reset_len_a: assert property ($rose(internalReset) |-> ##[1:24] !internalReset) // R20
        else $error("internal reset too long");
    area_trap_a: assert property (fetchValid && !trapAct_reg &&
                                  inArea(fetchAddr, wft_pkg::SREG_LO, wft_pkg::SREG_HI)
                                  |=> fetch_trap_irq) // R17
        else $error("special area fetch not trapped");
    pause_hold_a: assert property (pauseMode && !clearHit && running_reg
                                   |=> $stable(bin_reg)) // R22
        else $error("counter moved while paused");

    wd_irq_c: cover property (watchdog_irq);
    wd_reset_c: cover property ($rose(internalReset) && !fetch_trap_irq);
    trap_irq_c: cover property (fetch_trap_irq);
    disable_c: cover property ($fell(running_reg));

endmodule : wft_watchdog_trap

// >>> wft_cpu_model.sv
// CPU-side partner: register stores, register loads and instruction fetches
`timescale 1ns/1ps
module wft_cpu_model (
    input wire logic clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    output logic fetchValid,
    output logic [15:0] fetchAddr
);
    // Response ready held high, so no back-to-back clash on it
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid, fetchValid, fetchAddr} = '0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // whole-byte stores only
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        logic awOpen;
        logic wOpen;
        awOpen = 1'b1;
        wOpen = 1'b1;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awOpen && s_axi_awready === 1'b1) begin
                awOpen = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (wOpen && s_axi_wready === 1'b1) begin
                wOpen = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= {24'hffffff, ~d};
            end
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd
    task automatic fetch(input logic [15:0] a);
        fetchValid <= 1'b1;
        fetchAddr <= a;
        @(posedge clk);
        fetchValid <= 1'b0;
        fetchAddr <= ~a;
    endtask : fetch
    ////////////////////////////////////////////////////////////////////////////////
    // ordered stop sequence
    // Master flag already off and stack set; never run from a service task
    task automatic wd_off(input logic [7:0] ctl);
        logic [1:0] r;
        wr(wft_pkg::CODE_ADDR, wft_pkg::CLEAR_CODE, r);
        wr(wft_pkg::CTRL_ADDR, ctl, r);
        wr(wft_pkg::CODE_ADDR, wft_pkg::DISABLE_CODE, r);
    endtask : wd_off
endmodule : wft_cpu_model

// >>> tb_top.sv
// Self-checking bench for the watchdog and fetch-trap block
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, slowMode, slow_prescale_sel, slowTick, pauseMode, fetchValid;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic watchdog_irq, fetch_trap_irq, internalReset, fastOscRestart;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] fetchAddr;
    int errors, n_compared, n, k;
    int cyc = 0;
    wft_watchdog_trap wft_watchdog_trap_inst (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slowMode, .slow_prescale_sel,
        .slowTick, .pauseMode, .fetchValid, .fetchAddr, .watchdog_irq, .fetch_trap_irq,
        .internalReset, .fastOscRestart);
    wft_cpu_model wft_cpu_model_inst (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetchValid, .fetchAddr);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        wft_cpu_model_inst.wr(a, d, resp);
    endtask : wreg
    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        wft_cpu_model_inst.rd(wft_pkg::STAT_ADDR, data, resp);
        chk("status", exp, data & mask);
    endtask : stat
    task automatic trap(input logic [15:0] a, input logic exp);
        wft_cpu_model_inst.fetch(a);
        @(posedge clk);
        chk("trap irq", {31'h0, exp}, {31'h0, fetch_trap_irq});
    endtask : trap
    task automatic summarize;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Free cycle count, so bus write cycles are not lost from a measured span
    always @(posedge clk) cyc <= cyc + 1;
    // Whole run is near 8000 cycles; cut off well beyond that
    initial begin
        #500000;
        errors++;
        summarize();
    end
    initial begin
        {errors, n_compared, n, k} = '0;
        {rst_n, slow_prescale_sel, pauseMode} = '0;
        slowMode = 1'b1;
        slowTick = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        stat(32'hff, 32'h7c);
        wft_cpu_model_inst.rd(wft_pkg::CTRL_ADDR, data, resp);
        chk("control read", 32'h0, data);
        wft_cpu_model_inst.rd(8'h40, data, resp);
        chk("unmapped read", {30'h0, wft_pkg::RESP_ERR}, {30'h0, resp});
        wreg(8'h40, 8'h00);
        chk("unmapped write", {30'h0, wft_pkg::RESP_ERR}, {30'h0, resp});
        wft_cpu_model_inst.fetch(wft_pkg::SREG_HI);
        n = 0;
        while (internalReset === 1'b1 || n == 0) begin
            @(posedge clk);
            if (internalReset === 1'b1) n++; else n = (n == 0) ? 200 : n;
        end
        chk("trap reset length", wft_pkg::RESET_CYCLES, n);
        wreg(wft_pkg::CTRL_ADDR, 8'h3f);
        wreg(wft_pkg::CODE_ADDR, wft_pkg::CLEAR_CODE);
        n = 0;
        while (internalReset !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
            k += (fastOscRestart === 1'b1);
        end
        repeat (2) begin
            @(posedge clk);
            k += (fastOscRestart === 1'b1);
        end
        chk("reset overflow time", 1, (n >= 1536 && n <= 2060));
        chk("oscillator restart", 1, k);
        while (internalReset === 1'b1) @(posedge clk);
        wreg(wft_pkg::CTRL_ADDR, 8'h2e);
        trap(wft_pkg::BANK_LO, 1'b1);
        trap(wft_pkg::RAM_LO, 1'b1);
        trap(16'h0840, 1'b0);
        wreg(wft_pkg::CTRL_ADDR, 8'h0e);
        trap(wft_pkg::RAM_HI, 1'b1);
        wreg(wft_pkg::CODE_ADDR, wft_pkg::ARM_CODE);
        trap(wft_pkg::RAM_HI, 1'b0);
        trap(wft_pkg::SREG_LO, 1'b1);
        wreg(wft_pkg::CTRL_ADDR, 8'h0f);
        stat(32'h7c, 32'h18);
        slowMode <= 1'b0;
        slow_prescale_sel <= 1'b1;
        wreg(wft_pkg::CODE_ADDR, wft_pkg::CLEAR_CODE);
        k = 0;
        n = cyc;
        repeat (700) @(posedge clk);
        wreg(wft_pkg::CODE_ADDR, 8'h4f);
        pauseMode <= 1'b1;
        repeat (1000) begin
            @(posedge clk);
            k += (watchdog_irq === 1'b1);
        end
        pauseMode <= 1'b0;
        while (watchdog_irq !== 1'b1 && cyc - n < 4100) @(posedge clk);
        // Paused span does not count toward the overflow time
        n = cyc - n - 1000;
        chk("irq while paused", 0, k);
        chk("irq overflow time", 1, (n >= 1536 && n <= 2060));
        wreg(wft_pkg::CODE_ADDR, wft_pkg::DISABLE_CODE);
        stat(32'h08, 32'h08);
        wft_cpu_model_inst.wd_off(8'h06);
        stat(32'h1b, 32'h00);
        k = 0;
        repeat (2500) begin
            @(posedge clk);
            k += (watchdog_irq === 1'b1);
        end
        chk("irq while off", 0, k);
        wreg(wft_pkg::CTRL_ADDR, 8'h0e);
        wreg(wft_pkg::CODE_ADDR, wft_pkg::CLEAR_CODE);
        pauseMode <= 1'b1;
        repeat (50) @(posedge clk);
        pauseMode <= 1'b0;
        wreg(wft_pkg::CODE_ADDR, wft_pkg::CLEAR_CODE);
        stat(32'h18, 32'h18);
        summarize();
    end
endmodule : tb_top
